// ===== hw/mtb_irq.sv
// Shared, conversion and periodic interrupt controller with APB registers
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ns
module mtb_irq (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event sources
  input wire mtb_pkg::mtb_src_t src_flags,
  input wire logic conversion_done,
  input wire logic dedicated_period_clock,
  // Core vectoring
  input wire logic stack_full,
  input wire logic vec_ack,
  input wire logic return_from_irq_instr,
  output mtb_pkg::mtb_vec_t vec_req,
  // Status outputs
  output logic irq,
  output logic wake,
  output logic slow_crystal_low_power
);
  import mtb_pkg::*;

  logic [7:0] tbc_q;
  logic [NVEC-1:0] flags_q;
  logic [NVEC-1:0] flags_d;
  logic [NVEC-1:0] enable_q;
  logic global_irq_enable_q;
  logic wake_q;
  logic [31:0] prdata_q;
  logic [MF_SRC_W-1:0] prev_g0_q;
  logic [MF_SRC_W-1:0] prev_g1_q;
  logic [MF_SRC_W-1:0] prev_g2_q;
  logic [2:0] pclk_sync_q;
  logic pclk_level_q;
  logic [1:0] sys_div_q;
  logic [TB_CNT_W-1:0] cnt_q;
  logic sys_tick;
  logic ext_tick;
  logic tb_tick;
  logic [TB_CNT_W-1:0] mask0;
  logic [TB_CNT_W-1:0] mask1;
  logic tb0_ovf;
  logic tb1_ovf;
  logic [NVEC-1:0] set_ev;
  logic [NVEC-1:0] sw_clr;
  logic [NVEC-1:0] hw_clr;
  logic [NVEC-1:0] pending;
  logic take;
  logic wr;
  logic rd;
  logic addr_ok;
  logic period_dividers_on;
  logic period_clock_select;
  logic [1:0] period1_length_select;
  logic [2:0] period0_length_select;

  assign period_dividers_on = tbc_q[TBC_ON_BIT];
  assign period_clock_select = tbc_q[TBC_CLK_BIT];
  assign period1_length_select = tbc_q[TBC_P1_LSB +: 2];
  assign period0_length_select = tbc_q[TBC_P0_LSB +: 3];

  // ==========================================================
  // APB slave: zero wait states, error on unmapped address
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_q;

  always_comb begin
    if (paddr == ADDR_TBC) begin
      addr_ok = 1'b1;
    end else if (paddr == ADDR_FLAGS) begin
      addr_ok = 1'b1;
    end else if (paddr == ADDR_ENABLE) begin
      addr_ok = 1'b1;
    end else if (paddr == ADDR_GLOBAL) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign pslverr = psel & penable & ~addr_ok;

  // Read data is registered in the setup cycle so it is stable in access
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      if (paddr == ADDR_TBC) begin
        prdata_q <= {24'h00_0000, tbc_q};
      end else if (paddr == ADDR_FLAGS) begin
        prdata_q <= {26'h000_0000, flags_q};
      end else if (paddr == ADDR_ENABLE) begin
        prdata_q <= {26'h000_0000, enable_q};
      end else if (paddr == ADDR_GLOBAL) begin
        prdata_q <= {31'h0000_0000, global_irq_enable_q};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tbc_q <= TBC_RESET;
    end else if (wr && paddr == ADDR_TBC) begin
      tbc_q <= pwdata[7:0];
    end
  end

  assign slow_crystal_low_power = tbc_q[TBC_LP_BIT];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      enable_q <= ENABLE_RESET;
    end else if (wr && paddr == ADDR_ENABLE) begin
      enable_q <= pwdata[NVEC-1:0];
    end
  end

  // Order matters: return-from-interrupt set is checked first and wins over the vector entry clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      global_irq_enable_q <= GLOBAL_RESET;
    end else if (return_from_irq_instr) begin
      global_irq_enable_q <= 1'b1;
    end else if (take) begin
      global_irq_enable_q <= 1'b0;
    end else if (wr && paddr == ADDR_GLOBAL) begin
      global_irq_enable_q <= pwdata[0];
    end
  end

  // ==========================================================
  // Shared interrupt grouping: a source bit rising sets the group flag.
  // Source flags are only observed, never written back; software owns them.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prev_g0_q <= '0;
      prev_g1_q <= '0;
      prev_g2_q <= '0;
    end else begin
      prev_g0_q <= src_flags.g0;
      prev_g1_q <= src_flags.g1;
      prev_g2_q <= src_flags.g2;
    end
  end

  // ==========================================================
  // Period divider: clock select, prescale and overflow taps
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pclk_sync_q <= 3'h0;
    end else begin
      pclk_sync_q <= {pclk_sync_q[1:0], dedicated_period_clock};
    end
  end

  // Pin level is accepted only once stages two and three agree, so one
  // late sample cannot make a tick on its own
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pclk_level_q <= 1'b0;
    end else if (pclk_sync_q[1] == pclk_sync_q[2]) begin
      pclk_level_q <= pclk_sync_q[2];
    end
  end

  assign ext_tick = pclk_sync_q[1] & pclk_sync_q[2] & ~pclk_level_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sys_div_q <= 2'h0;
    end else begin
      sys_div_q <= sys_div_q + 2'h1;
    end
  end

  assign sys_tick = (sys_div_q == SYS_DIV_LAST);
  assign tb_tick = period_clock_select ? sys_tick : ext_tick;

  // Counter is held at zero while off so each period restarts cleanly
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (!period_dividers_on) begin
      cnt_q <= '0;
    end else if (tb_tick) begin
      cnt_q <= cnt_q + 15'h0001;
    end
  end

  assign mask0 = TB_CNT_W'((TB0_BASE << period0_length_select) - 16'h0001);
  assign mask1 = TB_CNT_W'((TB1_BASE << period1_length_select) - 16'h0001);
  assign tb0_ovf = period_dividers_on & tb_tick & ((cnt_q & mask0) == mask0);
  assign tb1_ovf = period_dividers_on & tb_tick & ((cnt_q & mask1) == mask1);

  // ==========================================================
  // Request flags: set wins over any clear in the same cycle
  always_comb begin
    set_ev = '0;
    set_ev[VEC_MF0] = |(src_flags.g0 & ~prev_g0_q);
    set_ev[VEC_MF1] = |(src_flags.g1 & ~prev_g1_q);
    set_ev[VEC_MF2] = |(src_flags.g2 & ~prev_g2_q);
    set_ev[VEC_AD] = conversion_done;
    set_ev[VEC_TB0] = tb0_ovf;
    set_ev[VEC_TB1] = tb1_ovf;
  end

  assign sw_clr = (wr && paddr == ADDR_FLAGS) ? pwdata[NVEC-1:0] : '0;

  always_comb begin
    hw_clr = '0;
    if (take) begin
      hw_clr[vec_req.id] = 1'b1;
    end
  end

  assign flags_d = (flags_q & ~sw_clr & ~hw_clr) | set_ev;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Wake ignores the enables so a sleeping core sees every new request
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= |(flags_d & ~flags_q);
    end
  end

  assign wake = wake_q;
  assign irq = |(flags_q & enable_q);

  // ==========================================================
  // Vector selection: fixed priority, lowest number first
  assign pending = flags_q & enable_q;

  always_comb begin
    vec_req.valid = 1'b0;
    vec_req.id = 3'h0;
    if (global_irq_enable_q && !stack_full) begin
      for (int i = NVEC - 1; i >= 0; i--) begin
        if (pending[i]) begin
          vec_req.valid = 1'b1;
          vec_req.id = 3'(i);
        end
      end
    end
  end

  assign take = vec_ack & vec_req.valid;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  gie_off_novec_a: assert property (!global_irq_enable_q |-> !vec_req.valid)
    else $error("vector offered with global enable off");
  stack_full_novec_a: assert property (stack_full |-> !vec_req.valid)
    else $error("vector offered with stack full");
  enable_needed_a: assert property (vec_req.valid |-> pending[vec_req.id])
    else $error("vector offered without flag and enable");
  entry_clears_gie_a: assert property (
    take && !return_from_irq_instr |=> !global_irq_enable_q)
    else $error("global enable not cleared on entry");
  entry_clears_flag_a: assert property (
    take && !set_ev[vec_req.id] |=> !flags_q[$past(vec_req.id)])
    else $error("serviced flag not cleared on entry");
  entry_clears_ad_a: assert property (
    take && vec_req.id == VEC_AD && !conversion_done
    |=> !flags_q[VEC_AD])
    else $error("conversion flag not cleared on entry");
  entry_clears_tb1_a: assert property (
    take && vec_req.id == VEC_TB1 && !tb1_ovf |=> !flags_q[VEC_TB1])
    else $error("period1 flag not cleared on entry");
  ad_sets_flag_a: assert property (conversion_done |=> flags_q[VEC_AD])
    else $error("conversion flag not set");
  return_from_irq_instr_sets_gie_a: assert property (
    return_from_irq_instr |=> global_irq_enable_q)
    else $error("return did not set global enable");
  tb_off_hold_a: assert property (!period_dividers_on |=> cnt_q == '0)
    else $error("divider runs while off");
  tb0_ovf_flag_a: assert property (tb0_ovf |=> flags_q[VEC_TB0])
    else $error("period0 overflow lost");
  tb1_ovf_flag_a: assert property (tb1_ovf |=> flags_q[VEC_TB1])
    else $error("period1 overflow lost");
  sys_div_four_a: assert property (
    sys_tick |=> !sys_tick [*3] ##1 sys_tick)
    else $error("system prescale not four");
  mf_group_set_a: assert property (
    $rose(src_flags.g1[0]) |=> flags_q[VEC_MF1])
    else $error("shared flag not set by source");
  flag_rise_wake_a: assert property (
    |(flags_q & ~$past(flags_q)) |-> wake)
    else $error("flag rise without wake");
  wake_needs_rise_a: assert property (
    wake |-> |(flags_q & ~$past(flags_q)))
    else $error("wake without a flag rise");

  vec_taken_c: cover property (take ##1 return_from_irq_instr);
  tb1_fire_c: cover property (tb1_ovf);
  nest_blocked_c: cover property (take ##1 (|flags_q && !vec_req.valid));
  mf_service_c: cover property (take && vec_req.id == VEC_MF0);
  ext_tick_c: cover property (ext_tick && !period_clock_select);
endmodule

// ===== hw/mtb_pkg.sv
// Package for the shared, conversion and periodic interrupt block
package mtb_pkg;
  // ==========================================================
  // Register byte addresses (APB, one aligned word each)
  localparam logic [7:0] ADDR_TBC = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_GLOBAL = 8'h0C;
  // ==========================================================
  // Period control register fields
  localparam int TBC_ON_BIT = 7;
  localparam int TBC_CLK_BIT = 6;
  localparam int TBC_P1_LSB = 4;
  localparam int TBC_LP_BIT = 3;
  localparam int TBC_P0_LSB = 0;
  localparam logic [7:0] TBC_RESET = 8'h37;
  // ==========================================================
  // Flag / enable layout (also the vector number, 0 = highest priority)
  localparam int NVEC = 6;
  localparam logic [2:0] VEC_MF0 = 3'h0;
  localparam logic [2:0] VEC_MF1 = 3'h1;
  localparam logic [2:0] VEC_MF2 = 3'h2;
  localparam logic [2:0] VEC_AD = 3'h3;
  localparam logic [2:0] VEC_TB0 = 3'h4;
  localparam logic [2:0] VEC_TB1 = 3'h5;
  localparam logic [NVEC-1:0] FLAGS_RESET = 6'h00;
  localparam logic [NVEC-1:0] ENABLE_RESET = 6'h00;
  localparam logic GLOBAL_RESET = 1'b0;
  // ==========================================================
  // Period divider
  localparam int TB_CNT_W = 15;
  localparam logic [15:0] TB0_BASE = 16'h0100;
  localparam logic [15:0] TB1_BASE = 16'h1000;
  localparam logic [1:0] SYS_DIV_LAST = 2'h3;
  localparam int MF_SRC_W = 8;
  // ==========================================================
  // Peripheral request flags grouped per shared interrupt
  typedef struct packed {
    logic [MF_SRC_W-1:0] g2;
    logic [MF_SRC_W-1:0] g1;
    logic [MF_SRC_W-1:0] g0;
  } mtb_src_t;
  // Vector request towards the core
  typedef struct packed {
    logic valid;
    logic [2:0] id;
  } mtb_vec_t;
endpackage

// ===== verification/mtb_core_model.sv
// Core-side model: takes offered vectors and issues returns
`timescale 1ns/1ns
module mtb_core_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Vector handshake
  input wire mtb_pkg::mtb_vec_t vec_req,
  output logic stack_full,
  output logic vec_ack,
  output logic return_from_irq_instr,
  // Bench control
  input wire logic full_in,
  input wire logic slow
);
  import mtb_pkg::*;
  int wait_q;
  int taken;
  logic [2:0] last_id;
  assign stack_full = full_in;
  initial return_from_irq_instr = 1'b0;
  // A slow core lets the offer stand before taking it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      vec_ack <= 1'b0;
      wait_q <= 0;
      taken <= 0;
      last_id <= 3'h7;
    end else if (vec_ack) begin
      vec_ack <= 1'b0;
      // An acknowledge that meets no offer is not a take
      if (vec_req.valid) begin
        taken <= taken + 1;
        last_id <= vec_req.id;
      end
      wait_q <= 0;
    end else if (vec_req.valid && !stack_full) begin
      if (wait_q >= (slow ? 3 : 0)) begin
        vec_ack <= 1'b1;
      end else begin
        wait_q <= wait_q + 1;
      end
    end else begin
      wait_q <= 0;
    end
  end
  task automatic give_return();
    @(posedge mclk);
    return_from_irq_instr <= 1'b1;
    @(posedge mclk);
    return_from_irq_instr <= 1'b0;
  endtask
endmodule

// ===== verification/mtb_irq_tb_top.sv
// Self-checking bench for the shared and periodic interrupt block
`timescale 1ns/1ns
module mtb_irq_tb_top;
  import mtb_pkg::*;
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  mtb_src_t src_flags;
  mtb_vec_t vec_req;
  logic conversion_done, dedicated_period_clock, stack_full, vec_ack;
  logic return_from_irq_instr, irq, wake, slow_crystal_low_power;
  logic full_in, slow;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int t0;
  mtb_irq dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_flags(src_flags),
    .conversion_done(conversion_done),
    .dedicated_period_clock(dedicated_period_clock),
    .stack_full(stack_full), .vec_ack(vec_ack),
    .return_from_irq_instr(return_from_irq_instr), .vec_req(vec_req),
    .irq(irq), .wake(wake), .slow_crystal_low_power(slow_crystal_low_power));
  mtb_core_model core (.mclk(mclk), .rstn(rstn), .vec_req(vec_req),
    .stack_full(stack_full), .vec_ack(vec_ack),
    .return_from_irq_instr(return_from_irq_instr), .full_in(full_in),
    .slow(slow));
  // ==========================================================
  // Clock, slow pin clock and timeout
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles % 8 == 0) dedicated_period_clock <= ~dedicated_period_clock;
    if (cycles == 30000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic check_val(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("Error %s expected %0h seen %0h", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [31:0] exp, string what);
    apb(a, 1'b0, 32'h0);
    check_val(what, exp, rd);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic test_regs();
    rd_chk(ADDR_TBC, {24'h0, TBC_RESET}, "ctrl reset");
    rd_chk(ADDR_FLAGS, 32'h0, "flags reset");
    rd_chk(ADDR_GLOBAL, 32'h0, "global reset");
    apb(ADDR_ENABLE, 1'b1, 32'h3F);
    rd_chk(ADDR_ENABLE, 32'h3F, "enable rw");
    apb(8'h10, 1'b0, 32'h0);
    check_val("unmapped err", 32'h1, {31'h0, err});
    check_val("unmapped data", 32'h0, rd);
    $display("test_regs done");
  endtask
  task automatic test_shared();
    apb(ADDR_ENABLE, 1'b1, 32'h02);
    for (int g = 0; g < 3; g++) begin
      src_flags <= 24'h1 << (8 * g);
      t0 = 0;
      repeat (4) begin
        @(negedge mclk);
        if (wake === 1'b1) t0 = 1;
      end
      check_val("wake", 32'h1, t0);
      rd_chk(ADDR_FLAGS, (32'h1 << (g + 1)) - 1, "group flag");
    end
    check_val("no vector", 32'h0, core.taken);
    apb(ADDR_FLAGS, 1'b1, 32'h05);
    apb(ADDR_GLOBAL, 1'b1, 32'h1);
    repeat (6) @(posedge mclk);
    check_val("mf id", 32'h1, {29'h0, core.last_id});
    rd_chk(ADDR_FLAGS, 32'h0, "mf flag clear");
    rd_chk(ADDR_GLOBAL, 32'h0, "global clear");
    src_flags <= '0;
    core.give_return();
    rd_chk(ADDR_GLOBAL, 32'h1, "global return");
    $display("test_shared done");
  endtask
  task automatic test_conv();
    full_in <= 1'b1;
    apb(ADDR_ENABLE, 1'b1, 32'h08);
    conversion_done <= 1'b1;
    @(posedge mclk);
    conversion_done <= 1'b0;
    repeat (5) @(posedge mclk);
    check_val("stack full", 32'h1, core.taken);
    rd_chk(ADDR_FLAGS, 32'h08, "conv flag");
    @(negedge mclk);
    check_val("irq high", 32'h1, {31'h0, irq});
    @(posedge mclk);
    full_in <= 1'b0;
    slow <= 1'b1;
    repeat (12) @(posedge mclk);
    check_val("conv id", 32'h3, {29'h0, core.last_id});
    rd_chk(ADDR_FLAGS, 32'h0, "conv clear");
    rd_chk(ADDR_GLOBAL, 32'h0, "conv global");
    @(negedge mclk);
    check_val("irq low", 32'h0, {31'h0, irq});
    @(posedge mclk);
    slow <= 1'b0;
    core.give_return();
    $display("test_conv done");
  endtask
  task automatic test_period();
    apb(ADDR_ENABLE, 1'b1, 32'h30);
    apb(ADDR_TBC, 1'b1, 32'hC9);
    t0 = cycles;
    @(negedge mclk);
    check_val("low power", 32'h1, {31'h0, slow_crystal_low_power});
    while (core.taken != 3 && cycles < t0 + 3000) @(posedge mclk);
    t0 = cycles - t0;
    check_val("p0 time", 32'h1, {31'h0, t0 >= 2040 && t0 <= 2060});
    check_val("p0 id", 32'h4, {29'h0, core.last_id});
    rd_chk(ADDR_FLAGS, 32'h0, "p0 clear");
    repeat (14250) @(posedge mclk);
    rd_chk(ADDR_FLAGS, 32'h10, "p1 early");
    repeat (160) @(posedge mclk);
    rd_chk(ADDR_FLAGS, 32'h30, "p1 flag");
    apb(ADDR_TBC, 1'b1, 32'h49);
    apb(ADDR_FLAGS, 1'b1, 32'h3F);
    repeat (2200) @(posedge mclk);
    rd_chk(ADDR_FLAGS, 32'h0, "dividers off");
    $display("test_period done");
  endtask
  // Dedicated pin clock, shortest first period: 256 rising pin edges
  task automatic test_ext();
    apb(ADDR_TBC, 1'b1, 32'h80);
    repeat (3900) @(posedge mclk);
    rd_chk(ADDR_FLAGS, 32'h0, "ext early");
    repeat (300) @(posedge mclk);
    rd_chk(ADDR_FLAGS, 32'h10, "ext flag");
    rd_chk(ADDR_TBC, 32'h80, "ctrl rw");
    check_val("lp off", 32'h0, {31'h0, slow_crystal_low_power});
    $display("test_ext done");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src_flags = '0;
    conversion_done = 1'b0;
    dedicated_period_clock = 1'b0;
    full_in = 1'b0;
    slow = 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    test_regs();
    test_shared();
    test_conv();
    test_period();
    test_ext();
    give_verdict();
  end
endmodule
